// ===== common/cis_pkg.sv
// constants, commands and states of the cpu interrupt sequencer
package cis_pkg;

	// ------------------------------------------------------------
	// vector table
	// ------------------------------------------------------------
	localparam logic [13:0] VEC_RESET = 14'h3FFE;
	localparam logic [13:0] VEC_SWTRAP = 14'h3FFC;
	localparam logic [13:0] VEC_EXT = 14'h3FFA;
	localparam int NUM_SRC = 6;

	// ------------------------------------------------------------
	// stack and flags
	// ------------------------------------------------------------
	localparam logic [9:0] SP_BASE = 10'h003;
	localparam logic [5:0] SP_TOP = 6'h3F;
	localparam logic [2:0] FLAGS_FIXED = 3'h7;
	localparam logic [1:0] IP_FIXED = 2'h0;
	localparam int FLAG_H = 4;
	localparam int FLAG_I = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;
	localparam logic [4:0] FLAGS_RESET = 5'h08;
	localparam logic [2:0] ENTRY_BYTES = 3'h5;
	localparam int LATENCY_EXTRA = 10;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int MUL_CYCLES = 11;
	localparam int MUL_STEPS = 8;

	// ------------------------------------------------------------
	// software register port
	// ------------------------------------------------------------
	localparam logic [1:0] REG_SRC_EN = 2'h0;
	localparam logic [1:0] REG_FLAGS = 2'h1;
	localparam logic [1:0] REG_IP_LO = 2'h2;
	localparam logic [1:0] REG_IP_HI = 2'h3;
	localparam logic [5:0] SRC_EN_RESET = 6'h3F;

	// ------------------------------------------------------------
	// read tags for returning memory bytes
	// ------------------------------------------------------------
	localparam logic [2:0] TAG_FLAGS = 3'h0;
	localparam logic [2:0] TAG_ACC = 3'h1;
	localparam logic [2:0] TAG_IDX = 3'h2;
	localparam logic [2:0] TAG_IP_HI = 3'h3;
	localparam logic [2:0] TAG_IP_LO = 3'h4;

	typedef enum logic [3:0] {
		CMD_NOP, CMD_FETCH, CMD_JUMP, CMD_ADD, CMD_ADC, CMD_SUB, CMD_AND, CMD_LDA,
		CMD_LDX, CMD_MUL, CMD_CLI, CMD_SEI, CMD_RSP, CMD_SWI, CMD_RTI, CMD_END
	} cis_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RSTVEC, ST_MUL, ST_PUSH, ST_VEC, ST_PULL, ST_WAIT
	} cis_state_t;

endpackage

// ===== src/cis_sequencer.sv
// sequencing, flags and interrupt entry/exit of the 8-bit core
`timescale 1ns/100ps

// Notes on behaviour
// - instruction pointer is 16 bits; top two bits always read 00
// - pointer steps by one per fetch; jumps and interrupt entry load it
// - flags register is 8 bits, top three bits read 111
// - half-carry set on carry from bit 3 to 4 in add and add-with-carry
// - unmasked request: push registers, set mask, then fetch the vector
// - request under mask is held until the mask clears
// - return pulls registers back, mask takes its stacked value, resumes at saved pointer
// - every reset sets the mask; only an instruction clears it
// - negative flag follows bit 7 of each add, subtract, and or load result; multiply leaves it
// - zero flag set when an add, subtract, and or load result is 00; multiply leaves it
// - carry on add carry out of bit 7 or subtract borrow
// - multiply is a shift-add chain lasting 11 cycles
// - requests wait for the running instruction to finish
// - entry only when mask clear and source enabled
// - pending sources chosen after stacking, highest vector first
// - reset loads pointer from the top vector pair and sets the mask
// - software trap ignores the mask and uses the pair below reset
// - unmasked software trap yields to pending hardware requests first
// - external, wide timer, serial link take the next three pairs
// - six sources; serial port, core timer, gauge take lowest pairs
// - request to first service fetch within longest instruction plus 10
// - stack pointer spans 64 bytes from C0 to FF and wraps
// - entry uses five stack bytes
module cis_sequencer
	import cis_pkg::*;
#(
	parameter int MUL_LEN = MUL_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic int_rst_req,
	// instruction commands
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic [15:0] cmd_addr,
	output logic cmd_ready,
	// program memory and stack
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_wr,
	output logic mem_rd,
	input wire logic [7:0] mem_rdata,
	// interrupt sources
	input wire logic [NUM_SRC-1:0] irq_req,
	output logic [NUM_SRC-1:0] irq_ack,
	// core state
	output logic [15:0] instruction_pointer,
	output logic [7:0] flags_register,
	output logic [7:0] acc_out,
	output logic [7:0] idx_out,
	// software register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata
);

	initial begin
		if (MUL_LEN < MUL_STEPS + 1 || MUL_LEN > 15)
			$error("cis_sequencer: MUL_LEN out of range");
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] first_src(input logic [NUM_SRC-1:0] p);
		logic [2:0] r;
		r = 3'h0;
		for (int k = NUM_SRC - 1; k >= 0; k--) begin
			if (p[k])
				r = 3'(k);
		end
		return r;
	endfunction

	function automatic logic [13:0] src_vec(input logic [2:0] s);
		return VEC_EXT - {10'h000, s, 1'b0};
	endfunction

	function automatic logic [15:0] stack_addr(input logic [5:0] sp);
		return {SP_BASE, sp};
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	cis_state_t state_q;
	logic [2:0] cnt_q;
	logic [3:0] mul_cnt_q;
	logic [13:0] ip_q;
	logic [13:0] ret_ip_q;
	logic [13:0] vec_q;
	logic [7:0] acc_q;
	logic [7:0] idx_q;
	logic [4:0] flags_q;
	logic [5:0] sp_q;
	logic [15:0] prod_q;
	logic take_hw_q;
	logic [NUM_SRC-1:0] snap_q;
	logic [NUM_SRC-1:0] src_en_q;
	logic ready_q;
	logic [15:0] mem_addr_q;
	logic [7:0] mem_wdata_q;
	logic mem_wr_q;
	logic mem_rd_q;
	logic [2:0] tag_q;
	logic rd_dly_q;
	logic [2:0] tag_dly_q;
	logic [NUM_SRC-1:0] ack_q;
	logic [7:0] reg_rdata_q;

	// ------------------------------------------------------------
	// decode and arithmetic
	// ------------------------------------------------------------
	cis_cmd_t op;
	logic take;
	logic [NUM_SRC-1:0] pend;
	logic [NUM_SRC-1:0] pend_sel;
	logic hw_go;
	logic cin;
	logic [8:0] add9;
	logic [4:0] half5;
	logic [8:0] sub9;
	logic [8:0] mstep;
	logic [7:0] res;

	assign op = cis_cmd_t'(cmd_op);
	assign take = cmd_valid && state_q == ST_IDLE;
	assign pend = irq_req & src_en_q;
	assign pend_sel = (|pend) ? pend : snap_q;
	assign hw_go = !flags_q[FLAG_I] && (|pend);
	assign cin = (op == CMD_ADC) ? flags_q[FLAG_C] : 1'b0;
	assign add9 = {1'b0, acc_q} + {1'b0, cmd_data} + {8'h00, cin};
	assign half5 = {1'b0, acc_q[3:0]} + {1'b0, cmd_data[3:0]} + {4'h0, cin};
	assign sub9 = {1'b0, acc_q} - {1'b0, cmd_data};
	assign mstep = {1'b0, prod_q[15:8]} + (prod_q[0] ? {1'b0, idx_q} : 9'h000);

	always_comb begin
		unique case (op)
			CMD_ADD, CMD_ADC: res = add9[7:0];
			CMD_SUB: res = sub9[7:0];
			CMD_AND: res = acc_q & cmd_data;
			default: res = cmd_data;
		endcase
	end

	// ------------------------------------------------------------
	// sequencer: states and memory cycles
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_RSTVEC;
			cnt_q <= 3'h0;
			mul_cnt_q <= 4'h0;
			ret_ip_q <= 14'h0000;
			vec_q <= VEC_RESET;
			take_hw_q <= 1'b0;
			snap_q <= '0;
			ready_q <= 1'b0;
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 8'h00;
			mem_wr_q <= 1'b0;
			mem_rd_q <= 1'b0;
			tag_q <= 3'h0;
			ack_q <= '0;
		end else begin
			mem_wr_q <= 1'b0;
			mem_rd_q <= 1'b0;
			ack_q <= '0;
			if (int_rst_req) begin
				state_q <= ST_RSTVEC;
				cnt_q <= 3'h0;
				vec_q <= VEC_RESET;
				ready_q <= 1'b0;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						cnt_q <= 3'h0;
						if (take) begin
							unique case (op)
								CMD_MUL: begin
									state_q <= ST_MUL;
									mul_cnt_q <= 4'h0;
									ready_q <= 1'b0;
								end
								CMD_SWI: begin
									// a pending unmasked request goes first; the trap re-runs
									state_q <= ST_PUSH;
									take_hw_q <= hw_go;
									snap_q <= pend;
									ret_ip_q <= hw_go ? ip_q - 14'h0001 : ip_q;
									ready_q <= 1'b0;
								end
								CMD_RTI: begin
									state_q <= ST_PULL;
									ready_q <= 1'b0;
								end
								CMD_END: begin
									if (hw_go) begin
										state_q <= ST_PUSH;
										take_hw_q <= 1'b1;
										snap_q <= pend;
										ret_ip_q <= ip_q;
										ready_q <= 1'b0;
									end
								end
								default: begin
								end
							endcase
						end
					end
					ST_MUL: begin
						mul_cnt_q <= mul_cnt_q + 4'h1;
						if (mul_cnt_q == 4'(MUL_LEN - 2)) begin
							state_q <= ST_IDLE;
							ready_q <= 1'b1;
						end
					end
					ST_PUSH: begin
						mem_wr_q <= 1'b1;
						mem_addr_q <= stack_addr(sp_q);
						unique case (cnt_q)
							3'h0: mem_wdata_q <= ret_ip_q[7:0];
							3'h1: mem_wdata_q <= {IP_FIXED, ret_ip_q[13:8]};
							3'h2: mem_wdata_q <= idx_q;
							3'h3: mem_wdata_q <= acc_q;
							default: mem_wdata_q <= {FLAGS_FIXED, flags_q};
						endcase
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == ENTRY_BYTES - 3'h1) begin
							state_q <= ST_VEC;
							cnt_q <= 3'h0;
							if (take_hw_q) begin
								vec_q <= src_vec(first_src(pend_sel));
							end else begin
								vec_q <= VEC_SWTRAP;
							end
						end
					end
					ST_VEC, ST_RSTVEC: begin
						mem_rd_q <= 1'b1;
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == 3'h0) begin
							mem_addr_q <= {IP_FIXED, vec_q};
							tag_q <= TAG_IP_HI;
							if (state_q == ST_VEC && take_hw_q)
								ack_q <= NUM_SRC'(1) << first_src(pend_sel);
						end else begin
							mem_addr_q <= {IP_FIXED, vec_q + 14'h0001};
							tag_q <= TAG_IP_LO;
							state_q <= ST_WAIT;
						end
					end
					ST_PULL: begin
						mem_rd_q <= 1'b1;
						mem_addr_q <= stack_addr(sp_q + 6'h01);
						tag_q <= cnt_q;
						cnt_q <= cnt_q + 3'h1;
						if (cnt_q == ENTRY_BYTES - 3'h1)
							state_q <= ST_WAIT;
					end
					ST_WAIT: begin
						if (!mem_rd_q && !rd_dly_q) begin
							state_q <= ST_IDLE;
							take_hw_q <= 1'b0;
							ready_q <= 1'b1;
						end
					end
					default: begin
						state_q <= ST_RSTVEC;
						cnt_q <= 3'h0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// read return pipe
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rd_dly_q <= 1'b0;
			tag_dly_q <= 3'h0;
		end else begin
			rd_dly_q <= mem_rd_q;
			tag_dly_q <= tag_q;
		end
	end

	// ------------------------------------------------------------
	// datapath: pointer, accumulator, index, flags, stack pointer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ip_q <= 14'h0000;
			acc_q <= 8'h00;
			idx_q <= 8'h00;
			flags_q <= FLAGS_RESET;
			sp_q <= SP_TOP;
			prod_q <= 16'h0000;
		end else if (int_rst_req) begin
			flags_q[FLAG_I] <= 1'b1;
			sp_q <= SP_TOP;
		end else begin
			if (take) begin
				unique case (op)
					CMD_FETCH: ip_q <= ip_q + 14'h0001;
					CMD_JUMP: ip_q <= cmd_addr[13:0];
					CMD_ADD, CMD_ADC: begin
						acc_q <= res;
						flags_q[FLAG_H] <= half5[4];
						flags_q[FLAG_C] <= add9[8];
						flags_q[FLAG_N] <= res[7];
						flags_q[FLAG_Z] <= res == 8'h00;
					end
					CMD_SUB: begin
						acc_q <= res;
						flags_q[FLAG_C] <= sub9[8];
						flags_q[FLAG_N] <= res[7];
						flags_q[FLAG_Z] <= res == 8'h00;
					end
					CMD_AND, CMD_LDA, CMD_LDX: begin
						if (op == CMD_LDX)
							idx_q <= res;
						else
							acc_q <= res;
						flags_q[FLAG_N] <= res[7];
						flags_q[FLAG_Z] <= res == 8'h00;
					end
					CMD_MUL: prod_q <= {8'h00, acc_q};
					CMD_CLI: flags_q[FLAG_I] <= 1'b0;
					CMD_SEI: flags_q[FLAG_I] <= 1'b1;
					CMD_RSP: sp_q <= SP_TOP;
					default: begin
					end
				endcase
			end
			if (state_q == ST_MUL) begin
				if (mul_cnt_q < 4'(MUL_STEPS))
					prod_q <= {mstep, prod_q[7:1]};
				if (mul_cnt_q == 4'(MUL_LEN - 2)) begin
					idx_q <= prod_q[15:8];
					acc_q <= prod_q[7:0];
					flags_q[FLAG_H] <= 1'b0;
					flags_q[FLAG_C] <= 1'b0;
				end
			end
			if (state_q == ST_PUSH) begin
				sp_q <= sp_q - 6'h01;
				if (cnt_q == ENTRY_BYTES - 3'h1)
					flags_q[FLAG_I] <= 1'b1;
			end
			if (state_q == ST_PULL)
				sp_q <= sp_q + 6'h01;
			if (rd_dly_q) begin
				unique case (tag_dly_q)
					TAG_FLAGS: flags_q <= mem_rdata[4:0];
					TAG_ACC: acc_q <= mem_rdata;
					TAG_IDX: idx_q <= mem_rdata;
					TAG_IP_HI: ip_q[13:8] <= mem_rdata[5:0];
					default: ip_q[7:0] <= mem_rdata;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// software register port
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			src_en_q <= SRC_EN_RESET;
			reg_rdata_q <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == REG_SRC_EN)
				src_en_q <= reg_wdata[NUM_SRC-1:0];
			reg_rdata_q <= 8'h00;
			if (reg_rd) begin
				unique case (reg_addr)
					REG_SRC_EN: reg_rdata_q <= {2'h0, src_en_q};
					REG_FLAGS: reg_rdata_q <= {FLAGS_FIXED, flags_q};
					REG_IP_LO: reg_rdata_q <= ip_q[7:0];
					default: reg_rdata_q <= {IP_FIXED, ip_q[13:8]};
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cmd_ready = ready_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign mem_wr = mem_wr_q;
	assign mem_rd = mem_rd_q;
	assign irq_ack = ack_q;
	assign instruction_pointer = {IP_FIXED, ip_q};
	assign flags_register = {FLAGS_FIXED, flags_q};
	assign acc_out = acc_q;
	assign idx_out = idx_q;
	assign reg_rdata = reg_rdata_q;

endmodule

// ===== tb/cis_sequencer_monitor.sv
// assertion checker of the interrupt sequencer
`timescale 1ns/100ps
module cis_sequencer_monitor
	import cis_pkg::*;
#(
	parameter int MUL_LEN = MUL_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic int_rst_req,
	// commands
	input wire logic cmd_valid,
	input wire logic [3:0] cmd_op,
	input wire logic cmd_ready,
	// memory and sources
	input wire logic [15:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_rd,
	input wire logic [NUM_SRC-1:0] irq_req,
	input wire logic [NUM_SRC-1:0] irq_ack,
	// core state
	input wire logic [15:0] instruction_pointer,
	input wire logic [7:0] flags_register,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	localparam int MUL_TAIL = MUL_LEN - 8;
	logic tk;
	logic msk;
	logic [NUM_SRC-1:0] en_q;
	// mirror of the source enables
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_q <= SRC_EN_RESET;
		end else if (reg_wr && reg_addr == REG_SRC_EN) begin
			en_q <= reg_wdata[NUM_SRC-1:0];
		end
	end
	assign tk = cmd_valid && cmd_ready && !int_rst_req;
	assign msk = flags_register[FLAG_I];
	// ----
	// properties
	// ----
	property p_ip_top;
		instruction_pointer[15:14] == IP_FIXED;
	endproperty
	a_ip_top: assert property (p_ip_top) else $error("pointer top bits set");
	property p_flags_top;
		flags_register[7:5] == FLAGS_FIXED;
	endproperty
	a_flags_top: assert property (p_flags_top) else $error("flags top bits wrong");
	property p_fetch;
		tk && cmd_op == CMD_FETCH |=>
			instruction_pointer[13:0] == $past(instruction_pointer[13:0]) + 14'h1;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch did not step");
	property p_rst_mask;
		int_rst_req |=> msk;
	endproperty
	a_rst_mask: assert property (p_rst_mask) else $error("reset left mask clear");
	property p_ack_mask;
		|irq_ack |-> msk && mem_rd;
	endproperty
	a_ack_mask: assert property (p_ack_mask) else $error("vector fetch unmasked");
	property p_masked;
		tk && cmd_op == CMD_END && msk |=> cmd_ready;
	endproperty
	a_masked: assert property (p_masked) else $error("masked request taken");
	property p_entry;
		tk && cmd_op == CMD_END && !msk && |(irq_req & en_q) |=>
			##1 mem_wr [*5] ##1 (mem_rd && mem_addr[15:4] == 12'h3FF);
	endproperty
	a_entry: assert property (p_entry) else $error("entry sequence wrong");
	property p_stack;
		mem_wr |-> mem_addr[15:6] == SP_BASE;
	endproperty
	a_stack: assert property (p_stack) else $error("stack outside range");
	property p_vec;
		mem_rd && mem_addr[15:4] == 12'h3FF && !mem_addr[0] |=>
			mem_rd && mem_addr == $past(mem_addr) + 16'h1;
	endproperty
	a_vec: assert property (p_vec) else $error("vector pair broken");
	property p_mul;
		tk && cmd_op == CMD_MUL |=> !cmd_ready [*8] ##MUL_TAIL cmd_ready;
	endproperty
	a_mul: assert property (p_mul) else $error("multiply length wrong");
	property p_swi;
		tk && cmd_op == CMD_SWI && msk |=>
			##1 mem_wr [*5] ##1 (mem_rd && mem_addr[13:0] == VEC_SWTRAP);
	endproperty
	a_swi: assert property (p_swi) else $error("trap vector wrong");
	c_mul: cover property (tk && cmd_op == CMD_MUL);
	c_ack: cover property (|irq_ack);
	c_swi: cover property (tk && cmd_op == CMD_SWI);
endmodule

bind cis_sequencer cis_sequencer_monitor #(.MUL_LEN(MUL_LEN)) u_mon (
	.clk_sys(clk_sys),
	.rst(rst),
	.int_rst_req(int_rst_req),
	.cmd_valid(cmd_valid),
	.cmd_op(cmd_op),
	.cmd_ready(cmd_ready),
	.mem_addr(mem_addr),
	.mem_wr(mem_wr),
	.mem_rd(mem_rd),
	.irq_req(irq_req),
	.irq_ack(irq_ack),
	.instruction_pointer(instruction_pointer),
	.flags_register(flags_register),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr)
);

// ===== tb/cis_partner.sv
// program memory, stack and interrupt sources
`timescale 1ns/100ps
module cis_partner
	import cis_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// source events
	input wire logic [NUM_SRC-1:0] set_req,
	input wire logic [NUM_SRC-1:0] irq_ack,
	output logic [NUM_SRC-1:0] irq_req,
	// memory port
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata
);
	logic [7:0] m [0:16383];
	initial begin
		mem_rdata = 8'h00;
		for (int i = 0; i < 16384; i++) begin
			m[i] = 8'(i) ^ 8'hA5;
		end
	end
	// data stands one cycle, then scrambles
	always @(posedge clk_sys) begin
		if (mem_wr) begin
			m[mem_addr[13:0]] <= mem_wdata;
		end
		mem_rdata <= mem_rd ? m[mem_addr[13:0]] : ~mem_rdata;
	end
	// flags held until acknowledged
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_req <= '0;
		end else begin
			irq_req <= (irq_req | set_req) & ~irq_ack;
		end
	end
endmodule

// ===== tb/test_cis_sequencer.sv
// self-checking bench of the interrupt sequencer
`timescale 1ns/100ps
module test_cis_sequencer import cis_pkg::*;;
	logic clk_sys, rst, int_rst_req, cmd_valid, cmd_ready, mem_wr, mem_rd, reg_wr, reg_rd;
	logic [3:0] cmd_op, mk;
	logic [7:0] cmd_data, mem_wdata, mem_rdata, acc_out, idx_out, reg_wdata, reg_rdata;
	logic [7:0] flags_register, a, b;
	logic [15:0] cmd_addr, mem_addr, instruction_pointer, pr;
	logic [1:0] reg_addr;
	logic [NUM_SRC-1:0] irq_req, irq_ack, set_req;
	logic [11:0] e;
	integer seed = 32'h8D4F;
	int failures, samples_checked, cyc;
	cis_cmd_t op;
	cis_cmd_t ops [4] = '{CMD_ADD, CMD_ADC, CMD_SUB, CMD_AND};
	cis_sequencer uut (.clk_sys(clk_sys), .rst(rst), .int_rst_req(int_rst_req),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_addr(cmd_addr),
		.cmd_ready(cmd_ready), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
		.mem_rd(mem_rd), .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_ack(irq_ack),
		.instruction_pointer(instruction_pointer), .flags_register(flags_register),
		.acc_out(acc_out), .idx_out(idx_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	cis_partner mdl (.clk_sys(clk_sys), .rst(rst), .set_req(set_req), .irq_ack(irq_ack),
		.irq_req(irq_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
		.mem_rd(mem_rd), .mem_rdata(mem_rdata));
	// ----
	// helpers
	// ----
	task automatic end_of_test;
		if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		samples_checked++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic wrdy;
		int n;
		n = 0;
		@(negedge clk_sys);
		while (cmd_ready !== 1'b1 && n < 30) begin
			n++;
			@(negedge clk_sys);
		end
		chk(16'(n < 30), 16'h1);
	endtask
	task automatic cmd(input cis_cmd_t o, input logic [7:0] d, input logic [15:0] ad);
		wrdy();
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_op <= o;
		cmd_data <= d;
		cmd_addr <= ad;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
	endtask
	task automatic rw(input logic [1:0] ad, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rr(input logic [1:0] ad, input logic [7:0] x);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(16'(reg_rdata), 16'(x));
	endtask
	function automatic logic [15:0] vip(input logic [13:0] v);
		logic [7:0] h, l;
		h = v[7:0] ^ 8'hA5;
		l = (v[7:0] + 8'h01) ^ 8'hA5;
		return {2'b00, h[5:0], l};
	endfunction
	function automatic logic [11:0] alu(input cis_cmd_t o, input logic [7:0] x, y,
		input logic ci);
		logic [8:0] s;
		logic [4:0] t;
		logic c;
		c = ci & (o == CMD_ADC);
		t = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
		case (o)
			CMD_SUB: s = {1'b0, x} - {1'b0, y};
			CMD_AND: s = {1'b0, x & y};
			default: s = {1'b0, x} + {1'b0, y} + {8'h00, c};
		endcase
		return {t[4], s[7], s[7:0] == 8'h00, s[8], s[7:0]};
	endfunction
	// ----
	// clock, timeout, sequence
	// ----
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		{rst, int_rst_req, cmd_valid, reg_wr, reg_rd} = 5'h10;
		{cmd_op, cmd_data, cmd_addr, reg_addr, reg_wdata, set_req} = '0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		wrdy();
		chk(instruction_pointer, vip(VEC_RESET));
		chk(16'(flags_register), 16'h00E8);
		rr(REG_SRC_EN, {2'h0, SRC_EN_RESET});
		rw(REG_SRC_EN, 8'h2A);
		rr(REG_SRC_EN, 8'h2A);
		rw(REG_FLAGS, 8'h00);
		rr(REG_FLAGS, 8'hE8);
		rw(REG_SRC_EN, 8'h3F);
		for (int i = 0; i < 24; i++) begin
			a = $random(seed);
			b = $random(seed);
			if (i < 8) begin
				a = (i < 4) ? 8'hFF : 8'h00;
				b = 8'h01;
			end
			op = ops[i % 4];
			mk = (op == CMD_AND) ? 4'h6 : (op == CMD_SUB) ? 4'h7 : 4'hF;
			cmd(CMD_LDA, a, 16'h0);
			@(negedge clk_sys);
			e = alu(op, a, b, flags_register[FLAG_C]);
			cmd(op, b, 16'h0);
			@(negedge clk_sys);
			chk(16'(acc_out), 16'(e[7:0]));
			chk(16'({flags_register[4], flags_register[2:0]} & mk), 16'(e[11:8] & mk));
		end
		cmd(CMD_JUMP, 8'h00, 16'hFFFF);
		@(negedge clk_sys);
		chk(instruction_pointer, 16'h3FFF);
		cmd(CMD_FETCH, 8'h00, 16'h0);
		@(negedge clk_sys);
		chk(instruction_pointer, 16'h0000);
		cmd(CMD_JUMP, 8'h00, 16'hC100);
		a = $random(seed);
		b = $random(seed);
		cmd(CMD_LDA, a, 16'h0);
		cmd(CMD_LDX, b, 16'h0);
		cmd(CMD_MUL, 8'h00, 16'h0);
		wrdy();
		pr = {8'h00, a} * {8'h00, b};
		chk({idx_out, acc_out}, pr);
		@(posedge clk_sys);
		set_req <= 6'h12;
		@(posedge clk_sys);
		set_req <= 6'h00;
		cmd(CMD_END, 8'h00, 16'h0);
		@(negedge clk_sys);
		chk(instruction_pointer, 16'h0100);
		cmd(CMD_LDA, 8'h5C, 16'h0);
		cmd(CMD_CLI, 8'h00, 16'h0);
		cmd(CMD_END, 8'h00, 16'h0);
		wrdy();
		chk(instruction_pointer, vip(14'h3FF8));
		chk(16'(flags_register[FLAG_I]), 16'h1);
		chk({mdl.m[14'h00FF], mdl.m[14'h00FE]}, 16'h0001);
		chk({mdl.m[14'h00FD], mdl.m[14'h00FC]}, {pr[15:8], 8'h5C});
		chk(16'(mdl.m[14'h00FB] & 8'hEE), 16'h00E0);
		cmd(CMD_RTI, 8'h00, 16'h0);
		wrdy();
		chk(instruction_pointer, 16'h0100);
		chk(16'(flags_register[FLAG_I]), 16'h0);
		cmd(CMD_SWI, 8'h00, 16'h0);
		wrdy();
		chk(instruction_pointer, vip(14'h3FF2));
		cmd(CMD_SWI, 8'h00, 16'h0);
		wrdy();
		chk(instruction_pointer, vip(VEC_SWTRAP));
		@(posedge clk_sys);
		int_rst_req <= 1'b1;
		@(posedge clk_sys);
		int_rst_req <= 1'b0;
		wrdy();
		chk(instruction_pointer, vip(VEC_RESET));
		chk(16'(flags_register), 16'h00E8);
		end_of_test();
	end
endmodule
